/* emi_defs.vh */
`ifndef EMI_DEFS_VH
`define EMI_DEFS_VH
// Register byte offsets
`define EMI_OFF_RX_EN 8'h00
`define EMI_OFF_TX_EN 8'h04
`define EMI_OFF_RXTH_EN 8'h08
`define EMI_OFF_MISC_EN 8'h0C
`define EMI_OFF_PACE_CTL 8'h10
`define EMI_OFF_RX_MAX 8'h14
`define EMI_OFF_TX_MAX 8'h18
`define EMI_OFF_MGMT_CTL 8'h20
`define EMI_OFF_MGMT_ALIVE 8'h24
`define EMI_OFF_MGMT_LINK 8'h28
`define EMI_OFF_MGMT_STAT 8'h2C
// Field positions
`define EMI_PACE_TX_BIT 16
`define EMI_PACE_RX_BIT 17
`define EMI_MGMT_EN_BIT 31
`define EMI_MGMT_PRE_BIT 20
`define EMI_DONE_BIT 0
// Reset values
`define EMI_RST_EN8 8'h00
`define EMI_RST_EN4 4'h0
`define EMI_RST_PACE 32'h00000000
`define EMI_RST_MAX 8'h00
// Timing
`define EMI_CLK_NS 40
`define EMI_MGMT_TARGET_NS 1000
`define EMI_DIV_RST (`EMI_MGMT_TARGET_NS / `EMI_CLK_NS - 1)
`define EMI_DIV_MIN 2'h3
`define EMI_PACE_BASE_NS 4000
`define EMI_WINDOW_NS 1000000
`define EMI_WINDOW_TICKS (`EMI_WINDOW_NS / `EMI_PACE_BASE_NS)
// Management frame layout, in bit slots
`define EMI_PRE_BITS 6'h20
`define EMI_HDR_END 46
`define EMI_TA_BIT 47
`define EMI_LAST_BIT 63
`define EMI_STAT_REG 5'h01
`define EMI_LINK_BIT 2
`endif

/* emi_mdio.v */
`timescale 1ns/1ps
`include "emi_defs.vh"
// Management engine: polls all PHY addresses with read frames of the status register
module emi_mdio #(
   parameter DIV_W = 16
) (
   input wire clk, // System clock
   input wire rst_n, // Synchronous reset, active low
   input wire enable, // Engine enable
   input wire pre_sup, // Skip the preamble
   input wire [DIV_W-1:0] div, // Clock divider
   input wire mdio_i, // Management data pin, input side
   output reg mdc_q, // Management clock
   output reg mdio_o_q, // Management data, output side
   output reg mdio_oe_n_q, // Output enable, low while driving
   output reg [31:0] alive_q, // PHY answered at this address
   output reg [31:0] link_q, // Link bit of that PHY
   output reg done_q, // A full sweep has completed
   output reg [4:0] addr_q // Address now being polled
);
   reg sy1_q;
   reg sy2_q;
   reg [DIV_W-1:0] cnt_q;
   reg [5:0] bit_q;
   reg ta_q;
   reg [15:0] data_q;
   wire [DIV_W-1:0] divm;
   wire [DIV_W-1:0] half;
   wire [13:0] hdr;
   wire [5:0] idx;
   wire [5:0] first_bit;
   wire [15:0] data_nx;

   // Floor of three: the pin reaches logic two clocks late, so shorter slots read stale data
   assign divm = (div < {{(DIV_W-2){1'b0}}, `EMI_DIV_MIN}) ?
      {{(DIV_W-2){1'b0}}, `EMI_DIV_MIN} : div;
   assign half = (divm + {{(DIV_W-1){1'b0}}, 1'b1}) >> 1;
   // Start, read opcode, PHY address, status register
   assign hdr = {4'h6, addr_q, `EMI_STAT_REG};
   assign idx = 6'h2D - bit_q;
   assign first_bit = pre_sup ? `EMI_PRE_BITS : 6'h00;
   // Data word as it stands once the current sample is shifted in
   assign data_nx = {data_q[14:0], sy2_q};

   // Pin synchroniser
   always @(posedge clk) begin
      if (!rst_n) begin
         sy1_q <= 1'b0;
         sy2_q <= 1'b0;
      end else begin
         sy1_q <= mdio_i;
         sy2_q <= sy1_q;
      end
   end

   // Bit engine: drive on the low phase, sample and step at period end
   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= {DIV_W{1'b0}};
         bit_q <= 6'h00;
         addr_q <= 5'h00;
         ta_q <= 1'b1;
         data_q <= 16'h0000;
         alive_q <= 32'h00000000;
         link_q <= 32'h00000000;
         done_q <= 1'b0;
         mdc_q <= 1'b0;
         mdio_o_q <= 1'b1;
         mdio_oe_n_q <= 1'b1;
      end else if (!enable) begin
         cnt_q <= {DIV_W{1'b0}};
         bit_q <= first_bit;
         addr_q <= 5'h00;
         done_q <= 1'b0; // Presence is stale until a new sweep ends
         mdc_q <= 1'b0;
         mdio_oe_n_q <= 1'b1;
      end else begin
         cnt_q <= (cnt_q >= divm) ? {DIV_W{1'b0}} : cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
         if (cnt_q == {DIV_W{1'b0}}) begin
            mdc_q <= 1'b0;
            if (bit_q < `EMI_PRE_BITS) begin
               mdio_o_q <= 1'b1;
               mdio_oe_n_q <= 1'b0;
            end else if (bit_q < `EMI_HDR_END) begin
               mdio_o_q <= hdr[idx[3:0]];
               mdio_oe_n_q <= 1'b0;
            end else begin
               mdio_oe_n_q <= 1'b1; // Turnaround and data belong to the PHY
            end
         end
         if (cnt_q == half) begin
            mdc_q <= 1'b1;
         end
         if (cnt_q >= divm) begin
            // Sampled late in the high phase, where the synchronised pin has settled
            if (bit_q == `EMI_TA_BIT) begin
               ta_q <= sy2_q;
            end
            if (bit_q > `EMI_TA_BIT) begin
               data_q <= data_nx;
            end
            if (bit_q == `EMI_LAST_BIT) begin
               // A PHY pulls the second turnaround bit low; the pull-up reads high
               alive_q[addr_q] <= ~ta_q;
               link_q[addr_q] <= ~ta_q & data_nx[`EMI_LINK_BIT];
               if (addr_q == 5'h1F) begin
                  done_q <= 1'b1;
               end
               addr_q <= addr_q + 5'h01; // Wraps to 0 and keeps polling
               bit_q <= first_bit;
            end else begin
               bit_q <= bit_q + 6'h01;
            end
         end
      end
   end
endmodule // emi_mdio

/* emi_top.v */
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "emi_defs.vh"
module emi_top #(
   parameter DIV_W = 16,
   parameter CNT_W = 8
) (
   input wire CLK_SYS, // System clock, 25 MHz
   input wire RESETN, // Synchronous reset, active low
   input wire [7:0] AWADDR, // Write address
   input wire AWVALID, // Write address valid
   output reg AWREADY, // Write address ready
   input wire [31:0] WDATA, // Write data
   input wire [3:0] WSTRB, // Byte strobes
   input wire WVALID, // Write data valid
   output reg WREADY, // Write data ready
   output reg [1:0] BRESP, // Write response
   output reg BVALID, // Write response valid
   input wire BREADY, // Write response ready
   input wire [7:0] ARADDR, // Read address
   input wire ARVALID, // Read address valid
   output reg ARREADY, // Read address ready
   output reg [31:0] RDATA, // Read data
   output reg [1:0] RRESP, // Read response
   output reg RVALID, // Read data valid
   input wire RREADY, // Read data ready
   input wire [7:0] RX_EVT, // Receive channel interrupt levels
   input wire [7:0] TX_EVT, // Transmit channel interrupt levels
   input wire [7:0] RXTH_EVT, // Receive threshold levels
   input wire [3:0] MISC_EVT, // Miscellaneous levels
   output wire RX_IRQ, // Receive interrupt to CPU
   output wire TX_IRQ, // Transmit interrupt to CPU
   output reg RXTH_IRQ, // Threshold interrupt to CPU
   output reg MISC_IRQ, // Miscellaneous interrupt to CPU
   output wire MDC, // Management clock
   input wire MDIO_I, // Management data in
   output wire MDIO_O, // Management data out
   output wire MDIO_OE_N // Management data enable, low drives
);
   reg [7:0] wrap_rx_irq_en_q;
   reg [7:0] wrap_tx_irq_en_q;
   reg [7:0] wrap_rx_low_buf_irq_en_q;
   reg [3:0] wrap_other_irq_en_q;
   reg [31:0] wrap_pacing_ctl_q;
   reg [CNT_W-1:0] rx_irq_per_ms_limit_q;
   reg [CNT_W-1:0] tx_irq_per_ms_limit_q;
   reg [31:0] mgmt_ctl_q;
   reg [7:0] aw_addr_q;
   reg aw_have_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_have_q;
   reg [15:0] pre_q;
   reg [15:0] win_q;
   reg win_tick_q;
   wire [31:0] alive;
   wire [31:0] link;
   wire sweep_done;
   wire [4:0] cur_addr;
   wire [1:0] pace_lvl;
   wire [1:0] pace_en;
   wire [2*CNT_W-1:0] pace_lim;
   wire [1:0] pace_irq;

   // Byte-lane merge for writes with strobes
   function [31:0] strb_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] strb;
      integer k;
      begin
         strb_merge = old_v;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               strb_merge[8*k +: 8] = new_v[8*k +: 8];
            end
         end
      end
   endfunction

   // Shared decode: is this word offset mapped
   function is_mapped;
      input [7:0] a;
      begin
         case (a)
            `EMI_OFF_RX_EN, `EMI_OFF_TX_EN, `EMI_OFF_RXTH_EN, `EMI_OFF_MISC_EN,
            `EMI_OFF_PACE_CTL, `EMI_OFF_RX_MAX, `EMI_OFF_TX_MAX, `EMI_OFF_MGMT_CTL,
            `EMI_OFF_MGMT_ALIVE, `EMI_OFF_MGMT_LINK, `EMI_OFF_MGMT_STAT: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // Read mux; enable and limit fields sit in low bits, the rest read zero
   function [31:0] rd_mux;
      input [7:0] a;
      reg [31:0] m;
      begin
         m = mgmt_ctl_q;
         case (a)
            `EMI_OFF_RX_EN: rd_mux = {24'h000000, wrap_rx_irq_en_q};
            `EMI_OFF_TX_EN: rd_mux = {24'h000000, wrap_tx_irq_en_q};
            `EMI_OFF_RXTH_EN: rd_mux = {24'h000000, wrap_rx_low_buf_irq_en_q};
            `EMI_OFF_MISC_EN: rd_mux = {28'h0000000, wrap_other_irq_en_q};
            `EMI_OFF_PACE_CTL: rd_mux = wrap_pacing_ctl_q;
            `EMI_OFF_RX_MAX: rd_mux = {{(32-CNT_W){1'b0}}, rx_irq_per_ms_limit_q};
            `EMI_OFF_TX_MAX: rd_mux = {{(32-CNT_W){1'b0}}, tx_irq_per_ms_limit_q};
            `EMI_OFF_MGMT_CTL: rd_mux = m;
            `EMI_OFF_MGMT_ALIVE: rd_mux = alive;
            `EMI_OFF_MGMT_LINK: rd_mux = link;
            `EMI_OFF_MGMT_STAT: rd_mux = {19'h00000, cur_addr, 7'h00, sweep_done};
            default: rd_mux = 32'h00000000;
         endcase
      end
   endfunction

   // Write channel: address and data taken in either order, response after both
   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         BVALID <= 1'b0;
         BRESP <= 2'h0;
         aw_addr_q <= 8'h00;
         aw_have_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         w_have_q <= 1'b0;
         wrap_rx_irq_en_q <= `EMI_RST_EN8;
         wrap_tx_irq_en_q <= `EMI_RST_EN8;
         wrap_rx_low_buf_irq_en_q <= `EMI_RST_EN8;
         wrap_other_irq_en_q <= `EMI_RST_EN4;
         wrap_pacing_ctl_q <= `EMI_RST_PACE;
         rx_irq_per_ms_limit_q <= `EMI_RST_MAX;
         tx_irq_per_ms_limit_q <= `EMI_RST_MAX;
         mgmt_ctl_q <= `EMI_DIV_RST;
      end else begin
         if (AWREADY && AWVALID) begin
            aw_addr_q <= {AWADDR[7:2], 2'b00};
            aw_have_q <= 1'b1;
            AWREADY <= 1'b0;
         end
         if (WREADY && WVALID) begin
            w_data_q <= WDATA;
            w_strb_q <= WSTRB;
            w_have_q <= 1'b1;
            WREADY <= 1'b0;
         end
         if (aw_have_q && w_have_q && !BVALID) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= is_mapped(aw_addr_q) ? 2'h0 : 2'h2;
            case (aw_addr_q)
               // Per-source enables, eight or four wide
               `EMI_OFF_RX_EN: wrap_rx_irq_en_q <= w_strb_q[0] ? w_data_q[7:0] : wrap_rx_irq_en_q;
               `EMI_OFF_TX_EN: wrap_tx_irq_en_q <= w_strb_q[0] ? w_data_q[7:0] : wrap_tx_irq_en_q;
               `EMI_OFF_RXTH_EN: wrap_rx_low_buf_irq_en_q <=
                  w_strb_q[0] ? w_data_q[7:0] : wrap_rx_low_buf_irq_en_q;
               `EMI_OFF_MISC_EN: wrap_other_irq_en_q <=
                  w_strb_q[0] ? w_data_q[3:0] : wrap_other_irq_en_q;
               `EMI_OFF_PACE_CTL: wrap_pacing_ctl_q <=
                  strb_merge(wrap_pacing_ctl_q, w_data_q, w_strb_q) & 32'h0003FFFF;
               `EMI_OFF_RX_MAX: rx_irq_per_ms_limit_q <=
                  w_strb_q[0] ? w_data_q[CNT_W-1:0] : rx_irq_per_ms_limit_q;
               `EMI_OFF_TX_MAX: tx_irq_per_ms_limit_q <=
                  w_strb_q[0] ? w_data_q[CNT_W-1:0] : tx_irq_per_ms_limit_q;
               // Enable, preamble suppress and divider in one word
               `EMI_OFF_MGMT_CTL: mgmt_ctl_q <=
                  strb_merge(mgmt_ctl_q, w_data_q, w_strb_q) & 32'h8010FFFF;
               default: mgmt_ctl_q <= mgmt_ctl_q;
            endcase
         end
         if (BVALID && BREADY) begin
            BVALID <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
      end
   end

   // Read channel: data one cycle after the address is taken
   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= 32'h00000000;
         RRESP <= 2'h0;
      end else if (ARREADY && ARVALID) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b1;
         RDATA <= rd_mux({ARADDR[7:2], 2'b00});
         RRESP <= is_mapped({ARADDR[7:2], 2'b00}) ? 2'h0 : 2'h2;
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
         ARREADY <= 1'b1;
      end
   end

   // Pacing time base: low field counts clocks per tick, ticks make one millisecond window
   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         pre_q <= 16'h0000;
         win_q <= 16'h0000;
         win_tick_q <= 1'b0;
      end else begin
         win_tick_q <= 1'b0;
         if (pre_q >= wrap_pacing_ctl_q[15:0]) begin
            pre_q <= 16'h0000;
            if (win_q >= `EMI_WINDOW_TICKS - 1) begin
               win_q <= 16'h0000;
               win_tick_q <= 1'b1;
            end else begin
               win_q <= win_q + 16'h0001;
            end
         end else begin
            pre_q <= pre_q + 16'h0001;
         end
      end
   end

   assign pace_lvl = {|(RX_EVT & wrap_rx_irq_en_q), |(TX_EVT & wrap_tx_irq_en_q)};
   assign pace_en = {wrap_pacing_ctl_q[`EMI_PACE_RX_BIT], wrap_pacing_ctl_q[`EMI_PACE_TX_BIT]};
   assign pace_lim = {rx_irq_per_ms_limit_q, tx_irq_per_ms_limit_q};

   // Paced lines: a new assertion is allowed only while under the per-window limit;
   // an asserted line holds so a level is never chopped mid-service
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pace
         reg irq_q;
         reg [CNT_W-1:0] cnt_q;
         wire want;
         assign want = pace_lvl[gi] &&
            (irq_q || !pace_en[gi] || cnt_q < pace_lim[gi*CNT_W +: CNT_W]);
         assign pace_irq[gi] = irq_q;
         always @(posedge CLK_SYS) begin
            if (!RESETN) begin
               irq_q <= 1'b0;
               cnt_q <= {CNT_W{1'b0}};
            end else begin
               irq_q <= want;
               if (win_tick_q) begin
                  cnt_q <= {CNT_W{1'b0}};
               end else if (want && !irq_q && cnt_q != {CNT_W{1'b1}}) begin
                  cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   endgenerate
   assign RX_IRQ = pace_irq[1];
   assign TX_IRQ = pace_irq[0];

   // Unpaced lines
   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         RXTH_IRQ <= 1'b0;
         MISC_IRQ <= 1'b0;
      end else begin
         RXTH_IRQ <= |(RXTH_EVT & wrap_rx_low_buf_irq_en_q);
         MISC_IRQ <= |(MISC_EVT & wrap_other_irq_en_q);
      end
   end

   // Management engine
   emi_mdio #(
      .DIV_W(DIV_W)
   ) u_mdio (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .enable(mgmt_ctl_q[`EMI_MGMT_EN_BIT]),
      .pre_sup(mgmt_ctl_q[`EMI_MGMT_PRE_BIT]),
      .div(mgmt_ctl_q[DIV_W-1:0]),
      .mdio_i(MDIO_I),
      .mdc_q(MDC),
      .mdio_o_q(MDIO_O),
      .mdio_oe_n_q(MDIO_OE_N),
      .alive_q(alive),
      .link_q(link),
      .done_q(sweep_done),
      .addr_q(cur_addr)
   );
endmodule // emi_top

/* emi_assertions.sv */
`timescale 1ns/1ps
module emi_checker (
   input wire CLK_SYS, // Clock
   input wire RESETN, // Reset, low active
   input wire AWVALID, // Bus
   input wire AWREADY, // Bus
   input wire WVALID, // Bus
   input wire WREADY, // Bus
   input wire BVALID, // Bus
   input wire BREADY, // Bus
   input wire [1:0] BRESP, // Bus
   input wire ARVALID, // Bus
   input wire ARREADY, // Bus
   input wire RVALID, // Bus
   input wire RREADY, // Bus
   input wire [31:0] RDATA, // Bus
   input wire [7:0] RX_EVT, // Events
   input wire [7:0] RXTH_EVT, // Events
   input wire [3:0] MISC_EVT, // Events
   input wire RX_IRQ, // Line
   input wire RXTH_IRQ, // Line
   input wire MISC_IRQ, // Line
   input wire MDC, // Link clock
   input wire MDIO_O, // Link data
   input wire MDIO_OE_N // Link enable, low drives
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);
   // Handshake steps of the two transfer kinds
   sequence wr_taken;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence
   sequence rd_taken;
      ARVALID && ARREADY;
   endsequence
   wr_resp_a: assert property (wr_taken |=> !AWREADY && !WREADY ##[0:1] BVALID)
      else $error("write not answered in time");
   rd_resp_a: assert property (rd_taken |=> !ARREADY ##[0:1] RVALID)
      else $error("read not answered in time");
   bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped early");
   rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped early");
   reset_idle_a: assert property ($rose(RESETN) |-> AWREADY && ARREADY && !BVALID && !MDC)
      else $error("outputs not idle after reset");
   misc_quiet_a: assert property (MISC_EVT == 4'h0 |=> !MISC_IRQ)
      else $error("misc line high without event");
   thresh_quiet_a: assert property (RXTH_EVT == 8'h00 |=> !RXTH_IRQ)
      else $error("threshold line high without event");
   rx_quiet_a: assert property (RX_EVT == 8'h00 |=> !RX_IRQ)
      else $error("receive line high without event");
   mdio_edge_a: assert property (!MDIO_OE_N && $changed(MDIO_O) |-> !MDC)
      else $error("link data moved while clock high");
   mdio_grab_a: assert property ($fell(MDIO_OE_N) |-> !MDC)
      else $error("link taken while clock high");
endmodule // emi_checker

bind emi_top emi_checker emi_checker_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
   .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
   .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
   .RREADY(RREADY), .RDATA(RDATA), .RX_EVT(RX_EVT), .RXTH_EVT(RXTH_EVT), .MISC_EVT(MISC_EVT),
   .RX_IRQ(RX_IRQ), .RXTH_IRQ(RXTH_IRQ), .MISC_IRQ(MISC_IRQ), .MDC(MDC), .MDIO_O(MDIO_O),
   .MDIO_OE_N(MDIO_OE_N));

/* emi_phy_model.sv */
`timescale 1ns/1ps
module emi_phy_model #(
   parameter [31:0] PRESENT = 32'h00000001,
   parameter [31:0] LINK = 32'h00000001
) (
   input wire mdc, // Link clock
   input wire mdio_oe_n, // Engine enable, low drives
   input wire mdio_line, // Resolved data line
   output reg phy_oe = 1'b0, // Model drives the line
   output reg phy_o = 1'b1 // Model data
);
   reg [13:0] hdr_q = 14'h3FFF;
   reg busy_q = 1'b0;
   reg [4:0] cnt_q = 5'h00;
   reg [4:0] addr_q = 5'h00;
   wire [13:0] hdr_d = {hdr_q[12:0], mdio_line};
   wire [15:0] stat_w = 16'h7809 | {13'h0000, LINK[addr_q], 2'h0};
   // Header is shifted in only while the engine drives, so answers never match a start
   always @(posedge mdc) begin
      if (busy_q) begin
         cnt_q <= cnt_q + 5'h01;
         if (cnt_q == 5'h11) begin
            busy_q <= 1'b0;
            hdr_q <= 14'h3FFF;
         end
      end else if (!mdio_oe_n) begin
         hdr_q <= hdr_d;
         if (hdr_d[13:10] == 4'h6 && hdr_d[4:0] == 5'h01) begin
            busy_q <= 1'b1;
            cnt_q <= 5'h00;
            addr_q <= hdr_d[9:5];
         end
      end
   end
   // Answer moves while the clock is low, so it is settled at the next rise
   always @(negedge mdc) begin
      phy_oe <= busy_q && PRESENT[addr_q] && cnt_q != 5'h00;
      phy_o <= (cnt_q == 5'h01) ? 1'b0 : stat_w[5'h11 - cnt_q];
   end
endmodule // emi_phy_model

/* emi_tb_top.sv */
`timescale 1ns/1ps
module emi_tb_top;
   localparam [31:0] PHY_HERE = 32'h00010024;
   localparam [31:0] PHY_UP = 32'h00000004;
   reg CLK_SYS = 1'b0;
   reg RESETN = 1'b0;
   reg AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   reg [7:0] AWADDR = 8'h00, ARADDR = 8'h00, RX_EVT = 8'h00, TX_EVT = 8'h00, RXTH_EVT = 8'h00;
   reg [3:0] MISC_EVT = 4'h0, WSTRB = 4'hF;
   reg [31:0] WDATA = 32'h00000000;
   reg [31:0] rd_last, t;
   reg [65:0] e;
   reg [65:0] q_rd[$];
   reg [1:0] q_wr[$];
   reg prev;
   integer bad_count = 0, n_compared = 0, cycles = 0, i, n;
   integer seed = 32'hB9EC85D2;
   time t0;
   wire AWREADY, WREADY, BVALID, ARREADY, RVALID, RX_IRQ, TX_IRQ, RXTH_IRQ, MISC_IRQ;
   wire MDC, MDIO_O, MDIO_OE_N, phy_oe, phy_o;
   wire [1:0] BRESP, RRESP;
   wire [31:0] RDATA;
   // Pull-up on the shared line: a released line reads one
   wire mdio_line = !MDIO_OE_N ? MDIO_O : (phy_oe ? phy_o : 1'b1);
   emi_top emi_top_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .RX_EVT(RX_EVT), .TX_EVT(TX_EVT), .RXTH_EVT(RXTH_EVT), .MISC_EVT(MISC_EVT),
      .RX_IRQ(RX_IRQ), .TX_IRQ(TX_IRQ), .RXTH_IRQ(RXTH_IRQ), .MISC_IRQ(MISC_IRQ), .MDC(MDC),
      .MDIO_I(mdio_line), .MDIO_O(MDIO_O), .MDIO_OE_N(MDIO_OE_N));
   emi_phy_model #(.PRESENT(PHY_HERE), .LINK(PHY_UP)) emi_phy_model_inst (.mdc(MDC),
      .mdio_oe_n(MDIO_OE_N), .mdio_line(mdio_line), .phy_oe(phy_oe), .phy_o(phy_o));
   // System clock
   initial begin
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   task check_bus(input [33:0] got, input [33:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
         end
      end
   endtask
   task check_pin(input [31:0] got, input [31:0] exp);
      begin
         check_bus({2'h0, got}, {2'h0, exp});
      end
   endtask
   task close_out;
      begin
         $display("compared %0d, mismatches %0d", n_compared, bad_count);
         if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // Address and data offered together, each released once taken
   task axi_write(input [7:0] a, input [31:0] d, input [1:0] r);
      begin
         q_wr.push_back(r);
         @(posedge CLK_SYS);
         AWADDR <= a;
         WDATA <= d;
         AWVALID <= 1'b1;
         WVALID <= 1'b1;
         BREADY <= 1'b1;
         do begin
            @(posedge CLK_SYS);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
         end while (!BVALID);
         BREADY <= 1'b0;
      end
   endtask
   // Mask selects which read bits are judged; polling reads judge none
   task axi_read(input [7:0] a, input [31:0] m, input [31:0] d, input [1:0] r);
      begin
         q_rd.push_back({r, m, d});
         @(posedge CLK_SYS);
         ARADDR <= a;
         ARVALID <= 1'b1;
         RREADY <= 1'b1;
         do begin
            @(posedge CLK_SYS);
            if (ARREADY) ARVALID <= 1'b0;
         end while (!RVALID);
         rd_last = RDATA;
         RREADY <= 1'b0;
      end
   endtask
   // Counts clock rises while the engine holds the line
   task driven_slots(input integer exp);
      begin
         @(negedge MDIO_OE_N);
         n = 0;
         while (!MDIO_OE_N) begin
            @(posedge MDC or posedge MDIO_OE_N);
            if (!MDIO_OE_N) n = n + 1;
         end
         check_pin(n, exp);
      end
   endtask
   task link_period(input integer exp);
      begin
         @(posedge MDC);
         t0 = $time;
         @(posedge MDC);
         check_pin(32'(($time - t0) / 40), exp);
      end
   endtask
   // Responses are judged against the oldest note
   always @(posedge CLK_SYS) begin
      if (BVALID && BREADY) check_bus({32'h0, BRESP}, {32'h0, q_wr.pop_front()});
      if (RVALID && RREADY) begin
         e = q_rd.pop_front();
         check_bus({RRESP, RDATA & e[63:32]}, {e[65:64], e[31:0]});
      end
   end
   // Hang guard, well above the expected run length
   always @(posedge CLK_SYS) begin
      cycles = cycles + 1;
      if (cycles == 40000) begin
         bad_count = bad_count + 1;
         close_out;
      end
   end
   initial begin
      repeat (10) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      for (i = 0; i < 7; i = i + 1) axi_read(8'(i * 4), 32'hFFFFFFFF, 32'h0, 2'h0);
      axi_read(8'h20, 32'hFFFFFFFF, 32'h00000018, 2'h0);
      // Clear the four per-source enable registers, then let the lines settle
      for (i = 0; i < 4; i = i + 1) axi_write(8'(i * 4), 32'h0, 2'h0);
      repeat (100) @(posedge CLK_SYS);
      for (i = 0; i < 4; i = i + 1) begin
         t = $random(seed);
         axi_write(8'(i * 4), t, 2'h0);
         axi_read(8'(i * 4), 32'hFFFFFFFF, t & ((i == 3) ? 32'hF : 32'hFF), 2'h0);
      end
      axi_write(8'h1C, 32'hFFFFFFFF, 2'h2);
      axi_read(8'h30, 32'hFFFFFFFF, 32'h0, 2'h2);
      for (i = 0; i < 4; i = i + 1) axi_write(8'(i * 4), 32'hFF, 2'h0);
      // Lane 0 off: an eight-bit enable must keep its value
      WSTRB <= 4'hE;
      axi_write(8'h00, 32'h0, 2'h0);
      WSTRB <= 4'hF;
      axi_read(8'h00, 32'hFFFFFFFF, 32'hFF, 2'h0);
      for (i = 0; i < 6; i = i + 1) begin
         t = $random(seed);
         TX_EVT <= t[7:0];
         RXTH_EVT <= t[15:8];
         MISC_EVT <= t[19:16];
         repeat (3) @(posedge CLK_SYS);
         check_pin({29'h0, TX_IRQ, RXTH_IRQ, MISC_IRQ},
            {29'h0, |t[7:0], |t[15:8], |t[19:16]});
      end
      MISC_EVT <= 4'hF;
      axi_write(8'h0C, 32'h0, 2'h0);
      repeat (3) @(posedge CLK_SYS);
      check_pin({31'h0, MISC_IRQ}, 32'h0);
      axi_write(8'h14, 32'h102, 2'h0);
      axi_read(8'h14, 32'hFFFFFFFF, 32'h02, 2'h0);
      axi_write(8'h10, 32'hFFFFFFFF, 2'h0);
      axi_read(8'h10, 32'hFFFFFFFF, 32'h0003FFFF, 2'h0);
      n = 0;
      prev = 1'b0;
      for (i = 0; i < 40; i = i + 1) begin
         @(posedge CLK_SYS);
         RX_EVT <= {7'h0, i[2]};
         if (RX_IRQ && !prev) n = n + 1;
         prev = RX_IRQ;
      end
      check_pin(n, 2);
      axi_write(8'h20, 32'h80000003, 2'h0);
      driven_slots(46);
      link_period(4);
      do begin
         repeat (200) @(posedge CLK_SYS);
         axi_read(8'h2C, 32'h0, 32'h0, 2'h0);
      end while (!rd_last[0]);
      axi_read(8'h24, 32'hFFFFFFFF, PHY_HERE, 2'h0);
      axi_read(8'h28, 32'hFFFFFFFF, PHY_UP, 2'h0);
      axi_write(8'h20, 32'h80100007, 2'h0);
      driven_slots(14);
      link_period(8);
      axi_write(8'h20, 32'h0, 2'h0);
      axi_read(8'h2C, 32'h1, 32'h0, 2'h0);
      check_pin({30'h0, MDC, MDIO_OE_N}, 32'h1);
      RESETN <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      axi_read(8'h00, 32'hFFFFFFFF, 32'h0, 2'h0);
      close_out;
   end
endmodule // emi_tb_top
